// >>> logic/aicf_defs.vh
// Constants for the converter input configuration and code formatter
`ifndef AICF_DEFS_VH
`define AICF_DEFS_VH
`define AICF_CFG_W        14
`define AICF_IC_HI        12
`define AICF_IC_LO        10
`define AICF_CH_HI        9
`define AICF_CH_LO        7
`define AICF_BW_BIT       6
`define AICF_IC_SINGLE    3'h7
`define AICF_IC_COM_BIP   3'h2
`define AICF_IC_COM_UNI   3'h6
`define AICF_IC_PAIR_BIP  2'h0
`define AICF_IC_PAIR_UNI  2'h2
`define AICF_MODE_SINGLE  2'h0
`define AICF_MODE_COM     2'h1
`define AICF_MODE_PAIR    2'h2
`define AICF_MODE_BAD     2'h3
`define AICF_UNI_TOP      16'hFFFF
`define AICF_UNI_BOT      16'h0000
`define AICF_BIP_TOP      16'h7FFF
`define AICF_BIP_BOT      16'h8000
`define AICF_MID          16'h8000
`define AICF_CFG_RST      14'h3FFF
`endif

// >>> logic/aicf_fmt.v
// Result code formatter: range clamp and binary or twos complement
`timescale 1ns/1ps
module aicf_fmt
(
  input  wire        ref_clk_in,  // Clock
  input  wire        rst_in,      // Async reset, high
  input  wire        en_in,       // Format strobe
  input  wire        bipolar_in,  // Range of this result
  input  wire [15:0] raw_in,      // Offset-binary core code
  input  wire        over_in,     // Input above full scale
  input  wire        under_in,    // Input below bottom
  output reg  [15:0] code_out,    // Formatted code
  output reg         valid_out    // Code strobe
);
`include "aicf_defs.vh"
  reg [15:0] code_d;
  // ==========================================================
  // Clamp, then choose format
  always @*
  begin
    if (over_in)
      code_d = bipolar_in ? `AICF_BIP_TOP : `AICF_UNI_TOP;
    else if (under_in)
      code_d = bipolar_in ? `AICF_BIP_BOT : `AICF_UNI_BOT;
    else if (bipolar_in)
      code_d = raw_in ^ `AICF_MID; // Twos complement
    else
      code_d = raw_in;             // Straight binary
  end
  // ==========================================================
  // Output register
  always @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      code_out  <= 16'h0000;
      valid_out <= 1'b0;
    end
    else
    begin
      valid_out <= en_in;
      if (en_in)
        code_out <= code_d;
    end
  end
endmodule

// >>> logic/aicf_top.v
// Input configuration decoder and result formatter top level
//
// Contract
// - Unipolar configurations give straight binary results
// - Bipolar configurations give twos complement results
// - Overrange clamps to top code, underrange to bottom code (0000 unipolar, 8000 bipolar)
// - Field 111 selects single-ended to ground
// - Field 010 selects bipolar against common
// - Field 110 selects unipolar against common
// - Field 00X selects bipolar differential pairs
// - Field 10X selects unipolar differential pairs
// - Paired: channel field names positive input
// - Bandwidth bit picks full or quarter
// - Configuration may change between conversions
// - Settings held in one 14-bit word
`timescale 1ns/1ps
module aicf_top
(
  input  wire        ref_clk_in,     // 200 MHz clock
  input  wire        rst_in,         // Async reset, high
  input  wire [13:0] cfg_word_in,    // Configuration word from port
  input  wire        cfg_load_in,    // Word load strobe
  input  wire        conv_start_in,  // Conversion start strobe
  input  wire        conv_done_in,   // Conversion finished strobe
  input  wire [15:0] raw_code_in,    // Core code, offset binary
  input  wire        over_in,        // Input above full scale
  input  wire        under_in,       // Input below bottom
  output reg  [1:0]  mode_out,       // 0 single,1 common,2 pair,3 bad
  output reg         bipolar_out,    // Bipolar range active
  output reg  [2:0]  pos_input_out,  // Positive mux input
  output reg  [2:0]  neg_input_out,  // Negative mux input
  output reg         neg_is_com_out, // Negative side is common pin
  output reg         neg_is_gnd_out, // Negative side is ground
  output reg         quarter_bw_out, // Quarter bandwidth filter
  output wire [15:0] result_out,     // Formatted result
  output wire        result_valid_out // Result strobe
);
`include "aicf_defs.vh"
  reg [13:0] cfg_q;
  reg        conv_bip_q;
  wire [2:0] input_config_field;
  wire [2:0] channel_select_field;
  wire       bandwidth_select;
  reg  [1:0] mode_d;
  reg        bip_d;
  reg  [2:0] pos_d;
  reg  [2:0] neg_d;
  // ==========================================================
  // Configuration word store; decode outputs follow a load next cycle, result range only from the next start
  always @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
      cfg_q <= `AICF_CFG_RST;
    else if (cfg_load_in)
      cfg_q <= cfg_word_in;
  end
  assign input_config_field   = cfg_q[`AICF_IC_HI:`AICF_IC_LO];
  assign channel_select_field = cfg_q[`AICF_CH_HI:`AICF_CH_LO];
  assign bandwidth_select     = cfg_q[`AICF_BW_BIT];
  // ==========================================================
  // Decode input configuration field
  always @*
  begin
    mode_d = `AICF_MODE_BAD;
    bip_d  = 1'b0;
    pos_d  = channel_select_field;
    neg_d  = channel_select_field;
    if (input_config_field == `AICF_IC_SINGLE)
      mode_d = `AICF_MODE_SINGLE;
    else if (input_config_field == `AICF_IC_COM_BIP)
    begin
      mode_d = `AICF_MODE_COM;
      bip_d  = 1'b1;
    end
    else if (input_config_field == `AICF_IC_COM_UNI)
      mode_d = `AICF_MODE_COM;
    else if (input_config_field[2:1] == `AICF_IC_PAIR_BIP)
    begin
      mode_d = `AICF_MODE_PAIR;
      bip_d  = 1'b1;
    end
    else if (input_config_field[2:1] == `AICF_IC_PAIR_UNI)
      mode_d = `AICF_MODE_PAIR;
    // Partner of a pair is the other member of the even/odd couple
    if (mode_d == `AICF_MODE_PAIR)
      neg_d = channel_select_field ^ 3'h1;
  end
  // ==========================================================
  // Registered decode outputs; 011 is unlisted, shown as bad mode
  always @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      mode_out       <= `AICF_MODE_SINGLE;
      bipolar_out    <= 1'b0;
      pos_input_out  <= 3'h7;
      neg_input_out  <= 3'h7;
      neg_is_com_out <= 1'b0;
      neg_is_gnd_out <= 1'b1;
      quarter_bw_out <= 1'b0;
    end
    else
    begin
      mode_out       <= mode_d;
      bipolar_out    <= bip_d;
      pos_input_out  <= pos_d;
      neg_input_out  <= neg_d;
      neg_is_com_out <= (mode_d == `AICF_MODE_COM);
      neg_is_gnd_out <= (mode_d == `AICF_MODE_SINGLE);
      // Bit low selects quarter; host must slow its rate
      quarter_bw_out <= ~bandwidth_select;
    end
  end
  // ==========================================================
  // Range latched at start so a late write cannot reformat
  always @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
      conv_bip_q <= 1'b0;
    else if (conv_start_in)
      conv_bip_q <= bip_d;
  end
  // ==========================================================
  // Formatter
  aicf_fmt u_fmt
  (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .en_in      (conv_done_in),
    .bipolar_in (conv_bip_q),
    .raw_in     (raw_code_in),
    .over_in    (over_in),
    .under_in   (under_in),
    .code_out   (result_out),
    .valid_out  (result_valid_out)
  );
endmodule

// >>> tb/aicf_top_properties.sv
// Checker for the input decoder and result formatter
`timescale 1ns/1ps
module aicf_top_checker
(
  input wire        ref_clk_in,
  input wire        rst_in,
  input wire [13:0] cfg_word_in,
  input wire        cfg_load_in,
  input wire        conv_done_in,
  input wire        over_in,
  input wire        under_in,
  input wire [1:0]  mode_out,
  input wire        bipolar_out,
  input wire [2:0]  pos_input_out,
  input wire [2:0]  neg_input_out,
  input wire        neg_is_com_out,
  input wire        neg_is_gnd_out,
  input wire        quarter_bw_out,
  input wire [15:0] result_out,
  input wire        result_valid_out
);
  // ====
  // Lone loads only: a second load overwrites before the check
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  wire [2:0] f  = cfg_word_in[12:10];
  wire       ld = cfg_load_in;
  chk_single_gnd: assert property (ld && f == 3'h7 ##1 !ld
    |=> mode_out == 2'h0 && !bipolar_out && neg_is_gnd_out)
    else $error("single");
  chk_com_bip: assert property (ld && f == 3'h2 ##1 !ld
    |=> mode_out == 2'h1 && bipolar_out && neg_is_com_out)
    else $error("com bip");
  chk_com_uni: assert property (ld && f == 3'h6 ##1 !ld
    |=> mode_out == 2'h1 && !bipolar_out && neg_is_com_out)
    else $error("com uni");
  chk_pair_bip: assert property (ld && f[2:1] == 2'h0 ##1 !ld
    |=> mode_out == 2'h2 && bipolar_out) else $error("pair bip");
  chk_pair_uni: assert property (ld && f[2:1] == 2'h2 ##1 !ld
    |=> mode_out == 2'h2 && !bipolar_out) else $error("pair uni");
  chk_pair_pos: assert property (ld && !f[1] ##1 !ld
    |=> pos_input_out == $past(cfg_word_in[9:7], 2)
    && neg_input_out == ($past(cfg_word_in[9:7], 2) ^ 3'h1))
    else $error("pair");
  chk_bw_pick: assert property (ld ##1 !ld
    |=> quarter_bw_out == !$past(cfg_word_in[6], 2)) else $error("bw");
  chk_valid_pulse: assert property (conv_done_in ##1 !conv_done_in
    |-> result_valid_out ##1 !result_valid_out) else $error("valid");
  chk_over_clamp: assert property (conv_done_in && over_in
    |=> result_out == 16'hFFFF || result_out == 16'h7FFF) else $error("over");
  chk_under_clamp: assert property (conv_done_in && under_in && !over_in
    |=> result_out == 16'h0000 || result_out == 16'h8000) else $error("under");
endmodule
bind aicf_top aicf_top_checker aicf_top_checker_i (.ref_clk_in, .rst_in,
  .cfg_word_in, .cfg_load_in, .conv_done_in, .over_in, .under_in, .mode_out,
  .bipolar_out, .pos_input_out, .neg_input_out, .neg_is_com_out,
  .neg_is_gnd_out, .quarter_bw_out, .result_out, .result_valid_out);

// >>> tb/aicf_host.sv
// Host model: writes the configuration word and paces conversions
`timescale 1ns/1ps
module aicf_host
(
  input  wire        ref_clk_in, // Clock
  output reg  [13:0] cw_out,     // Configuration word
  output reg         ld_out,     // Load strobe
  output reg         st_out,     // Start strobe
  output reg         dn_out,     // Done strobe
  output reg  [15:0] raw_out,    // Core code
  output reg         ov_out,     // Above full scale
  output reg         un_out      // Below bottom
);
  reg qbw = 1'b0;
  initial {cw_out, ld_out, st_out, dn_out, raw_out, ov_out, un_out} = 35'h0;
  // Whole word per load; released bus shows the inverse
  task write_cfg(input [13:0] w);
  begin
    @(negedge ref_clk_in) {cw_out, ld_out, qbw} = {w, 1'b1, !w[6]};
    @(negedge ref_clk_in) {cw_out, ld_out} = {~w, 1'b0};
  end
  endtask
  // Start, optional mid-conversion load, then done with the code
  task convert(input [15:0] r, input o, u, c, input [13:0] w);
    integer k;
  begin
    @(negedge ref_clk_in) st_out = 1'b1;
    for (k = 0; k < (qbw ? 16 : 4); k++)
      @(negedge ref_clk_in) {st_out, ld_out, cw_out} = {1'b0, c && k == 0, w};
    {dn_out, raw_out, ov_out, un_out} = {1'b1, r, o, u};
    @(negedge ref_clk_in) {dn_out, raw_out, ov_out, un_out} = {1'b0, ~r, !o, !u};
  end
  endtask
endmodule

// >>> tb/aicf_top_tb_top.sv
// Self-checking bench for the decoder and formatter
`timescale 1ns/1ps
module aicf_top_tb_top;
  reg ref_clk_in = 1'b0, rst_in = 1'b1;
  wire [13:0] cfg_word_in;
  wire cfg_load_in, conv_start_in, conv_done_in, over_in, under_in;
  wire [15:0] raw_code_in, result_out;
  wire [1:0] mode_out;
  wire [2:0] pos_input_out, neg_input_out;
  wire bipolar_out, neg_is_com_out, neg_is_gnd_out, quarter_bw_out;
  wire result_valid_out;
  integer mismatches = 0, n_tests = 0, i, k, seed = 32'h522aa107;
  reg [13:0] w, w2;
  reg [15:0] r;
  initial forever #2.5 ref_clk_in = ~ref_clk_in;
  aicf_host aicf_host_i (.ref_clk_in, .cw_out(cfg_word_in),
    .ld_out(cfg_load_in),
    .st_out(conv_start_in), .dn_out(conv_done_in), .raw_out(raw_code_in),
    .ov_out(over_in), .un_out(under_in));
  aicf_top aicf_top_i (.ref_clk_in, .rst_in, .cfg_word_in, .cfg_load_in,
    .conv_start_in, .conv_done_in, .raw_code_in, .over_in, .under_in, .mode_out,
    .bipolar_out, .pos_input_out, .neg_input_out, .neg_is_com_out,
    .neg_is_gnd_out, .quarter_bw_out, .result_out, .result_valid_out);
  // ====
  // Expected {mode, bipolar} for a field value
  function [2:0] dm(input [2:0] f);
    dm = f == 3'h7 ? 3'h0 : f == 3'h3 ? 3'h6 : f == 3'h2 ? 3'h3 :
         f == 3'h6 ? 3'h2 : f[2] ? 3'h4 : 3'h5;
  endfunction
  function [15:0] fmt(input b, o, u, input [15:0] x);
    fmt = o ? (b ? 16'h7FFF : 16'hFFFF) : u ? (b ? 16'h8000 : 16'h0000) :
          b ? x ^ 16'h8000 : x;
  endfunction
  task check(input string nm, input [15:0] seen, exp);
  begin
    n_tests++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch %s exp %h seen %h", nm, exp, seen);
    end
  end
  endtask
  task chk_cfg(input [13:0] v);
  begin
    check("mode", 16'({mode_out, bipolar_out}), 16'(dm(v[12:10])));
    check("bw", 16'(quarter_bw_out), 16'(!v[6]));
    if (!v[11])
      check("mux", 16'({pos_input_out, neg_input_out}), 16'({v[9:7],
        v[9:7] ^ 3'h1}));
  end
  endtask
  task give_verdict;
  begin
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  end
  endtask
  // Every field value twice, then conversions with late config changes
  initial
  begin
    repeat (2) @(negedge ref_clk_in);
    rst_in = 1'b0;
    for (i = 0; i < 16; i++)
    begin
      w = $random(seed);
      w[12:10] = i;
      aicf_host_i.write_cfg(w);
      @(negedge ref_clk_in) chk_cfg(w);
    end
    $display("test decode done");
    for (i = 0; i < 24; i++)
    begin
      {w, w2, r} = {$random(seed), $random(seed)};
      r = i < 2 ? {16{i[0]}} : r;
      aicf_host_i.write_cfg(w);
      aicf_host_i.convert(r, i % 4 == 1, i % 4 > 1, i[0], w2);
      for (k = 0; result_valid_out !== 1'b1 && k < 4; k++)
        @(negedge ref_clk_in);
      if (k == 4) mismatches++;
      if (k == 4) give_verdict;
      check("code", result_out, fmt(dm(w[12:10]) % 2,
        i % 4 == 1, i % 4 > 1, r));
      if (i[0]) chk_cfg(w2);
    end
    $display("test convert done");
    give_verdict;
  end
endmodule
